// *** hdl/ptw_unit.v ***
// Purpose: Periodic timer and watchdog unit with its register port.
// Assumes: slow_clock is asynchronous to mclk and far slower than it.
// Notes: All counting advances on synchronised slow clock rising edges.
`timescale 1ns/10ps
`include "ptw_map.vh"

module ptw_unit #(
  parameter ADDR_W = 24,
  parameter PRESET_W = 16,
  parameter WD_W = 8
) (
  input wire mclk,
  input wire rst,
  input wire slow_clock,
  input wire [1:0] power_mode,
  input wire [ADDR_W-1:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  output reg periodic_pulse,
  output reg periodic_timer_irq,
  output reg watchdog_reset
);

////////////////////////////////////////////////////////////////////////////////

reg slow_meta;
reg slow_sync;
reg slow_prev;
wire halted;
wire slow_edge;

assign halted = (power_mode == `PTW_MODE_HALT);
// Halt gates the only time base, so every counter holds its state.
assign slow_edge = slow_sync & ~slow_prev & ~halted;

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    slow_meta <= 1'b0;
    slow_sync <= 1'b0;
    slow_prev <= 1'b0;
  end else begin
    slow_meta <= slow_clock;
    slow_sync <= slow_meta;
    slow_prev <= slow_sync;
  end
end

////////////////////////////////////////////////////////////////////////////////

reg lock_config;
reg lock_prescaler;
reg lock_periodic_timer;
reg lock_reload_count;
reg watchdog_clock_select;
reg match_service_enable;
reg [2:0] prescale_select;
reg [PRESET_W-1:0] periodic_preset;
reg periodic_irq_enable;
reg restart_req;
reg terminal_count_flag;
reg [WD_W-1:0] watchdog_reload_count;

wire active;
wire hit_cfg;
wire hit_pre;
wire hit_preset;
wire hit_csr;
wire hit_wdc;
wire hit_match;
wire acc_cfg;
wire acc_pre;
wire acc_tmr;
wire acc_wdc;

assign active = (power_mode == `PTW_MODE_ACTIVE);
assign hit_cfg = (addr == `PTW_ADR_CFG);
assign hit_pre = (addr == `PTW_ADR_PRE);
assign hit_preset = (addr == `PTW_ADR_PRESET);
assign hit_csr = (addr == `PTW_ADR_CSR);
assign hit_wdc = (addr == `PTW_ADR_WDCOUNT);
assign hit_match = (addr == `PTW_ADR_MATCH);

// Outside Active mode only the match register stays reachable, and Halt shuts it too.
// Each lock bit shuts its own register or register pair.
assign acc_cfg = active & ~lock_config;
assign acc_pre = active & ~lock_prescaler;
assign acc_tmr = active & ~lock_periodic_timer;
assign acc_wdc = active & ~lock_reload_count;

wire wr_cfg;
wire wr_pre;
wire wr_preset;
wire wr_csr;
wire wr_wdc;
wire wr_match;
wire rd_csr;

assign wr_cfg = wr & hit_cfg & acc_cfg;
assign wr_pre = wr & hit_pre & acc_pre;
assign wr_preset = wr & hit_preset & acc_tmr;
assign wr_csr = wr & hit_csr & acc_tmr;
assign wr_wdc = wr & hit_wdc & acc_wdc;
assign wr_match = wr & hit_match & ~halted;
assign rd_csr = rd & hit_csr & acc_tmr;

////////////////////////////////////////////////////////////////////////////////

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    // Reset clears every defined configuration bit.
    lock_config <= 1'b0;
    lock_prescaler <= 1'b0;
    lock_periodic_timer <= 1'b0;
    lock_reload_count <= 1'b0;
    watchdog_clock_select <= 1'b0;
    match_service_enable <= 1'b0;
  end else if (wr_cfg) begin
    // Lock bits can be set but never cleared by a write.
    lock_config <= lock_config | wdata[`PTW_CFG_LOCK_CFG];
    lock_prescaler <= lock_prescaler | wdata[`PTW_CFG_LOCK_PRE];
    lock_periodic_timer <= lock_periodic_timer | wdata[`PTW_CFG_LOCK_TMR];
    lock_reload_count <= lock_reload_count | wdata[`PTW_CFG_LOCK_WDC];
    watchdog_clock_select <= wdata[`PTW_CFG_CLK_SEL];
    match_service_enable <= wdata[`PTW_CFG_MATCH_EN];
  end
end

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    prescale_select <= 3'h0;
  end else if (wr_pre) begin
    prescale_select <= wdata[2:0];
  end
end

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    periodic_preset <= `PTW_RST_PRESET;
  end else if (wr_preset) begin
    periodic_preset <= wdata[PRESET_W-1:0];
  end
end

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    periodic_irq_enable <= 1'b0;
  end else if (wr_csr) begin
    periodic_irq_enable <= wdata[`PTW_CSR_IRQ_EN];
  end
end

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    watchdog_reload_count <= `PTW_RST_WDCOUNT;
  end else if (wr_wdc) begin
    watchdog_reload_count <= wdata[WD_W-1:0];
  end
end

////////////////////////////////////////////////////////////////////////////////

reg [4:0] pre_cnt;
reg [4:0] pre_last;
reg tick;

// Codes 000 to 101 pick divisors 1 to 32; reserved codes act as 32.
always @* begin
  case (prescale_select)
    3'h0: pre_last = 5'h00;
    3'h1: pre_last = 5'h01;
    3'h2: pre_last = 5'h03;
    3'h3: pre_last = 5'h07;
    3'h4: pre_last = 5'h0F;
    default: pre_last = 5'h1F;
  endcase
end

// One tick per divisor count of slow clock edges.
always @(posedge mclk or posedge rst) begin
  if (rst) begin
    pre_cnt <= 5'h00;
    tick <= 1'b0;
  end else begin
    tick <= 1'b0;
    if (slow_edge) begin
      if (pre_cnt >= pre_last) begin
        pre_cnt <= 5'h00;
        tick <= 1'b1;
      end else begin
        pre_cnt <= pre_cnt + 5'h01;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////

reg [PRESET_W-1:0] tmr_cnt;
reg pulse_set;

// The count steps only on ticks and reloads only at zero or restart.
always @(posedge mclk or posedge rst) begin
  if (rst) begin
    tmr_cnt <= `PTW_RST_PRESET;
    periodic_pulse <= 1'b0;
    pulse_set <= 1'b0;
  end else begin
    pulse_set <= 1'b0;
    if (tick) begin
      periodic_pulse <= 1'b0;
      if (restart_req) begin
        tmr_cnt <= periodic_preset;
      end else if (tmr_cnt == {PRESET_W{1'b0}}) begin
        // Preset is sampled only here and on restart, so live writes never disturb it.
        tmr_cnt <= periodic_preset;
      end else begin
        tmr_cnt <= tmr_cnt - {{(PRESET_W-1){1'b0}}, 1'b1};
        if (tmr_cnt == {{(PRESET_W-1){1'b0}}, 1'b1}) begin
          // High from the tick that reaches zero to the next tick.
          periodic_pulse <= 1'b1;
          pulse_set <= 1'b1;
        end
      end
    end
  end
end

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    restart_req <= 1'b0;
  end else if (wr_csr & wdata[`PTW_CSR_RESTART]) begin
    restart_req <= 1'b1;
  end else if (tick) begin
    restart_req <= 1'b0;
  end
end

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    terminal_count_flag <= 1'b0;
  end else if (pulse_set) begin
    // Setting wins over a status read in the same cycle.
    terminal_count_flag <= 1'b1;
  end else if (rd_csr) begin
    terminal_count_flag <= 1'b0;
  end
end

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    periodic_timer_irq <= 1'b0;
  end else begin
    periodic_timer_irq <= periodic_pulse & periodic_irq_enable;
  end
end

////////////////////////////////////////////////////////////////////////////////

reg wd_running;
reg [WD_W-1:0] wd_cnt;
reg wd_serviced;
reg [2:0] settle_cnt;
wire wd_edge;
wire key_ok;
wire match_live;
wire wd_load;
wire wd_err;

// The watchdog clock is the tick or the rising periodic pulse.
assign wd_edge = watchdog_clock_select ? tick : pulse_set;
assign key_ok = (wdata[WD_W-1:0] == `PTW_SERVICE_KEY);
// Match writes count only while the match method is on.
assign match_live = wr_match & match_service_enable;
// Count writes reload directly only with the match method off.
assign wd_load = (wr_wdc & ~match_service_enable) | (match_live & key_ok);

// Late, too often or wrong key each raise an error.
assign wd_err = wd_running & ((wd_edge & (wd_cnt == {WD_W{1'b0}}) & ~wd_load)
  | (match_live & ~key_ok) | (match_live & key_ok & wd_serviced));

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    wd_running <= 1'b0;
  end else if (wr_wdc | match_live) begin
    wd_running <= 1'b1;
  end
end

// Counter moves only once started; reset is the only way to stop it.
always @(posedge mclk or posedge rst) begin
  if (rst) begin
    wd_cnt <= `PTW_RST_WDCOUNT;
  end else if (wr_wdc & ~match_service_enable) begin
    wd_cnt <= wdata[WD_W-1:0];
  end else if (match_live & key_ok) begin
    wd_cnt <= watchdog_reload_count;
  end else if (wd_running & wd_edge & (wd_cnt != {WD_W{1'b0}})) begin
    wd_cnt <= wd_cnt - {{(WD_W-1){1'b0}}, 1'b1};
  end
end

// Remembers a service within the current watchdog clock cycle.
always @(posedge mclk or posedge rst) begin
  if (rst) begin
    wd_serviced <= 1'b0;
  end else if (match_live & key_ok) begin
    wd_serviced <= 1'b1;
  end else if (wd_edge) begin
    wd_serviced <= 1'b0;
  end
end

// Error is held until the device reset it causes arrives.
always @(posedge mclk or posedge rst) begin
  if (rst) begin
    watchdog_reset <= 1'b0;
  end else if (wd_err) begin
    watchdog_reset <= 1'b1;
  end
end

// Busy flag covers the settling time after watchdog writes.
always @(posedge mclk or posedge rst) begin
  if (rst) begin
    settle_cnt <= 3'h0;
  end else if (wr_wdc | match_live) begin
    settle_cnt <= `PTW_SETTLE_SLOW;
  end else if (slow_edge & (settle_cnt != 3'h0)) begin
    settle_cnt <= settle_cnt - 3'h1;
  end
end

////////////////////////////////////////////////////////////////////////////////

reg [15:0] next_rdata;

always @* begin
  next_rdata = 16'h0000;
  if (hit_cfg) begin
    if (acc_cfg) begin
      next_rdata = {10'h000, match_service_enable, watchdog_clock_select,
        lock_reload_count, lock_periodic_timer, lock_prescaler, lock_config};
    end else begin
      next_rdata = `PTW_LOCKED_READ;
    end
  end else if (hit_pre) begin
    if (acc_pre) begin
      next_rdata = {13'h0000, prescale_select};
    end else begin
      next_rdata = `PTW_LOCKED_READ;
    end
  end else if (hit_preset) begin
    if (acc_tmr) begin
      next_rdata = periodic_preset;
    end else begin
      next_rdata = `PTW_LOCKED_READ;
    end
  end else if (hit_csr) begin
    if (acc_tmr) begin
      next_rdata = {12'h000, (settle_cnt != 3'h0) | restart_req,
        periodic_irq_enable, terminal_count_flag, restart_req};
    end else begin
      next_rdata = `PTW_LOCKED_READ;
    end
  end
end

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    rdata <= 16'h0000;
  end else if (rd) begin
    rdata <= next_rdata;
  end else begin
    rdata <= 16'h0000;
  end
end

endmodule // ptw_unit

// *** hdl/ptw_map.vh ***
// Purpose: Constants for the periodic timer and watchdog unit.
// Assumes: Byte registers use the low data bits; upper bits read zero.
// Notes: Offsets are the full bus addresses of the register port.
`ifndef PTW_MAP_VH
`define PTW_MAP_VH
`define PTW_ADR_CFG 24'hFFFF20
`define PTW_ADR_PRE 24'hFFFF22
`define PTW_ADR_PRESET 24'hFFFF24
`define PTW_ADR_CSR 24'hFFFF26
`define PTW_ADR_WDCOUNT 24'hFFFF28
`define PTW_ADR_MATCH 24'hFFFF2A
`define PTW_CFG_LOCK_CFG 0
`define PTW_CFG_LOCK_PRE 1
`define PTW_CFG_LOCK_TMR 2
`define PTW_CFG_LOCK_WDC 3
`define PTW_CFG_CLK_SEL 4
`define PTW_CFG_MATCH_EN 5
`define PTW_CSR_RESTART 0
`define PTW_CSR_TC 1
`define PTW_CSR_IRQ_EN 2
`define PTW_CSR_BUSY 3
`define PTW_RST_PRESET 16'hFFFF
`define PTW_RST_WDCOUNT 8'h0F
`define PTW_SERVICE_KEY 8'h5C
`define PTW_SETTLE_SLOW 3'h5
`define PTW_MODE_ACTIVE 2'h0
`define PTW_MODE_HALT 2'h3
`define PTW_LOCKED_READ 16'h0000
`endif

// *** bench/ptw_unit_properties.sv ***
// Purpose: Port-level checks for the periodic timer and watchdog unit.
// Assumes: Bound to every ptw_unit instance; one clock domain.
// Notes: Helper flags remember watchdog starts and recent reads.
`timescale 1ns/10ps
`include "ptw_map.vh"

module ptw_unit_properties #(
  parameter ADDR_W = 24
) (
  input wire mclk,
  input wire rst,
  input wire slow_clock,
  input wire [1:0] power_mode,
  input wire [ADDR_W-1:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  input wire periodic_pulse,
  input wire periodic_timer_irq,
  input wire watchdog_reset
);
  reg started;
  reg csr_rd;
  reg lp_rd;

  // The start flag is a superset: any write outside Halt near the two watchdog registers.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      started <= 1'h0;
      csr_rd <= 1'h0;
      lp_rd <= 1'h0;
    end else begin
      if (wr && power_mode != 2'h3 && addr[3] && !addr[2])
        started <= 1'h1;
      csr_rd <= rd && addr == `PTW_ADR_CSR && power_mode == 2'h0;
      lp_rd <= rd && power_mode[1] != power_mode[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_wd_sticky: assert property (watchdog_reset |=> watchdog_reset)
    else $error("watchdog reset dropped");
  chk_wd_quiet: assert property (watchdog_reset |-> started)
    else $error("watchdog error before any start");
  chk_irq_cause: assert property (periodic_timer_irq |-> $past(periodic_pulse))
    else $error("interrupt without periodic pulse");
  chk_irq_drop: assert property ($fell(periodic_pulse) |=> !periodic_timer_irq)
    else $error("interrupt outlives periodic pulse");
  chk_read_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside read slot");
  chk_lowpower_read: assert property (lp_rd |-> rdata == 16'h0000)
    else $error("register readable in low power mode");
  chk_flag_clear: assert property ($past(csr_rd) && rd && addr == `PTW_ADR_CSR &&
    power_mode == 2'h0 && !periodic_pulse && !$past(periodic_pulse) |=> rdata[1] == 1'h0)
    else $error("terminal count not cleared by status read");
  chk_halt_freeze: assert property ((power_mode == 2'h3) [*4] |->
    $stable(periodic_pulse) && $stable(watchdog_reset))
    else $error("outputs moved during halt");
endmodule // ptw_unit_properties

bind ptw_unit ptw_unit_properties #(.ADDR_W(ADDR_W)) i_chk (
  .mclk(mclk), .rst(rst), .slow_clock(slow_clock), .power_mode(power_mode),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .periodic_pulse(periodic_pulse), .periodic_timer_irq(periodic_timer_irq),
  .watchdog_reset(watchdog_reset)
);

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the periodic timer and watchdog unit.
// Assumes: Slow clock is made as one eighth of mclk.
// Notes: Each scenario task drives the block and judges the result.
`timescale 1ns/10ps
`include "ptw_map.vh"
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin failures++; \
  $display("Error %s expected %h seen %h", n, e, v); end end

module tb;
  reg mclk = 1'h0;
  reg rst = 1'h1;
  reg [2:0] slow_div = 3'h0;
  reg [1:0] power_mode = 2'h0;
  reg [23:0] addr = 24'h000000;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'h0;
  reg rd = 1'h0;
  wire [15:0] rdata;
  wire periodic_pulse;
  wire periodic_timer_irq;
  wire watchdog_reset;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  reg [15:0] d;
  int t0, t1, t2, i;

  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    slow_div <= slow_div + 3'h1;
    cyc <= cyc + 1;
  end

  ptw_unit i_dut (
    .mclk(mclk), .rst(rst), .slow_clock(slow_div[2]), .power_mode(power_mode),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .periodic_pulse(periodic_pulse), .periodic_timer_irq(periodic_timer_irq),
    .watchdog_reset(watchdog_reset)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    begin
      $display("Comparisons %0d, mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  task automatic do_reset;
    begin
      rst <= 1'h1;
      power_mode <= 2'h0;
      repeat (20) @(posedge mclk);
      rst <= 1'h0;
      @(posedge mclk);
    end
  endtask

  task automatic wrr(input [23:0] a, input [15:0] v);
    begin
      addr <= a;
      wdata <= v;
      wr <= 1'h1;
      @(posedge mclk);
      wr <= 1'h0;
      @(posedge mclk);
    end
  endtask

  task automatic rdr(input [23:0] a);
    begin
      addr <= a;
      rd <= 1'h1;
      @(posedge mclk);
      rd <= 1'h0;
      @(posedge mclk);
      d = rdata;
    end
  endtask

  task automatic rise(output int t);
    int k;
    begin
      k = 0;
      while (periodic_pulse !== 1'h0 && k < 3000) begin
        @(posedge mclk);
        k++;
      end
      while (periodic_pulse !== 1'h1 && k < 3000) begin
        @(posedge mclk);
        k++;
      end
      t = cyc;
      `CHK("pulse seen", 1'h1, k < 3000)
    end
  endtask

  // Services the watchdog three times, each 26 mclk after the last.
  task automatic serve3(input [23:0] a, input [15:0] v);
    begin
      for (i = 0; i < 3; i++) begin
        repeat (24) @(posedge mclk);
        wrr(a, v);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    begin
      rdr(`PTW_ADR_CFG);
      `CHK("config", 16'h0000, d)
      rdr(`PTW_ADR_PRESET);
      `CHK("preset", 16'hFFFF, d)
      rdr(`PTW_ADR_CSR);
      `CHK("status", 16'h0000, d)
      wrr(`PTW_ADR_CFG, 16'h0010);
      wrr(`PTW_ADR_MATCH, 16'h005B);
      repeat (160) @(posedge mclk);
      `CHK("wd idle", 1'h0, watchdog_reset)
      wrr(`PTW_ADR_CFG, 16'h0030);
      wrr(`PTW_ADR_MATCH, 16'h005C);
      repeat (110) @(posedge mclk);
      `CHK("wd early", 1'h0, watchdog_reset)
      repeat (50) @(posedge mclk);
      `CHK("wd late", 1'h1, watchdog_reset)
    end
  endtask

  task automatic t_period;
    int c, w;
    begin
      do_reset;
      wrr(`PTW_ADR_PRESET, 16'h0001);
      wrr(`PTW_ADR_CSR, 16'h0005);
      for (c = 0; c < 6; c++) begin
        wrr(`PTW_ADR_PRE, c[15:0]);
        rise(t0);
        rise(t1);
        `CHK("period", 16 << c, t1 - t0)
        @(posedge mclk);
        `CHK("irq", 1'h1, periodic_timer_irq)
        w = 1;
        while (periodic_pulse === 1'h1 && w < 3000) begin
          @(posedge mclk);
          w++;
        end
        `CHK("pulse width", 8 << c, w)
        rdr(`PTW_ADR_CSR);
        `CHK("flag set", 1'h1, d[1])
        rdr(`PTW_ADR_CSR);
        `CHK("flag clear", 1'h0, d[1])
      end
    end
  endtask

  task automatic t_defer_restart;
    begin
      wrr(`PTW_ADR_PRE, 16'h0000);
      wrr(`PTW_ADR_PRESET, 16'h0003);
      rise(t0);
      rise(t0);
      repeat (12) @(posedge mclk);
      wrr(`PTW_ADR_PRESET, 16'h0001);
      rise(t1);
      `CHK("old preset", 32, t1 - t0)
      rise(t2);
      `CHK("new preset", 16, t2 - t1)
      repeat (10) @(posedge mclk);
      wrr(`PTW_ADR_CSR, 16'h0003);
      rise(t0);
      `CHK("restart", 24, t0 - t2)
      @(posedge mclk);
      `CHK("irq off", 1'h0, periodic_timer_irq)
      rdr(`PTW_ADR_CSR);
      `CHK("restart bit", 1'h0, d[0])
    end
  endtask

  task automatic t_direct;
    begin
      do_reset;
      wrr(`PTW_ADR_CFG, 16'h0010);
      wrr(`PTW_ADR_WDCOUNT, 16'h0004);
      serve3(`PTW_ADR_WDCOUNT, 16'h0004);
      repeat (28) @(posedge mclk);
      `CHK("served", 1'h0, watchdog_reset)
      repeat (22) @(posedge mclk);
      `CHK("late", 1'h1, watchdog_reset)
    end
  endtask

  // The watchdog runs from the periodic pulse, one edge every 16 mclk.
  task automatic t_pulse_clock;
    begin
      do_reset;
      wrr(`PTW_ADR_PRESET, 16'h0001);
      wrr(`PTW_ADR_CSR, 16'h0001);
      wrr(`PTW_ADR_WDCOUNT, 16'h0002);
      repeat (29) @(posedge mclk);
      `CHK("pulse clocked", 1'h0, watchdog_reset)
      repeat (25) @(posedge mclk);
      `CHK("pulse late", 1'h1, watchdog_reset)
    end
  endtask

  task automatic t_match;
    begin
      do_reset;
      wrr(`PTW_ADR_CFG, 16'h0030);
      wrr(`PTW_ADR_WDCOUNT, 16'h0006);
      serve3(`PTW_ADR_MATCH, 16'h005C);
      `CHK("match served", 1'h0, watchdog_reset)
      wrr(`PTW_ADR_MATCH, 16'h005B);
      `CHK("bad key", 1'h1, watchdog_reset)
      do_reset;
      wrr(`PTW_ADR_CFG, 16'h0030);
      wrr(`PTW_ADR_WDCOUNT, 16'h0006);
      addr <= `PTW_ADR_MATCH;
      wdata <= 16'h005C;
      wr <= 1'h1;
      repeat (3) @(posedge mclk);
      wr <= 1'h0;
      repeat (3) @(posedge mclk);
      `CHK("too often", 1'h1, watchdog_reset)
    end
  endtask

  task automatic t_lock;
    begin
      do_reset;
      wrr(`PTW_ADR_CFG, 16'h0018);
      wrr(`PTW_ADR_WDCOUNT, 16'h0001);
      repeat (60) @(posedge mclk);
      `CHK("locked count", 1'h0, watchdog_reset)
      wrr(`PTW_ADR_CFG, 16'h0004);
      rdr(`PTW_ADR_CFG);
      `CHK("locks kept", 16'h000C, d)
      rdr(`PTW_ADR_PRESET);
      `CHK("locked preset", 16'h0000, d)
      wrr(`PTW_ADR_CFG, 16'h0001);
      rdr(`PTW_ADR_CFG);
      `CHK("locked config", 16'h0000, d)
    end
  endtask

  task automatic t_power;
    begin
      do_reset;
      wrr(`PTW_ADR_CFG, 16'h0030);
      wrr(`PTW_ADR_WDCOUNT, 16'h0006);
      rdr(`PTW_ADR_CSR);
      `CHK("busy", 1'h1, d[3])
      repeat (40) @(posedge mclk);
      rdr(`PTW_ADR_CSR);
      `CHK("settled", 1'h0, d[3])
      power_mode <= 2'h1;
      serve3(`PTW_ADR_MATCH, 16'h005C);
      power_mode <= 2'h2;
      wrr(`PTW_ADR_PRE, 16'h0005);
      rdr(`PTW_ADR_CFG);
      `CHK("save read", 16'h0000, d)
      `CHK("save serve", 1'h0, watchdog_reset)
      power_mode <= 2'h3;
      repeat (200) @(posedge mclk);
      `CHK("halt", 1'h0, watchdog_reset)
      power_mode <= 2'h0;
      repeat (80) @(posedge mclk);
      `CHK("resume", 1'h1, watchdog_reset)
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 20000);
    failures++;
    end_sim;
  end

  initial begin
    do_reset;
    t_reset;
    t_period;
    t_defer_restart;
    t_direct;
    t_pulse_clock;
    t_match;
    t_lock;
    t_power;
    end_sim;
  end
endmodule // tb
